//--- hw/scrb_map.vh
// register offsets, field positions and reset values of the serial configuration bank
`ifndef SCRB_MAP_VH
`define SCRB_MAP_VH

`define SCRB_ADDR_W          15
`define SCRB_OFF_CONFIG_A_RESET_AND_DIRECTION        15'h0000
`define SCRB_OFF_CONFIG_B_RESERVED        15'h0001
`define SCRB_OFF_POWER       15'h0002
`define SCRB_OFF_CLASS       15'h0003
`define SCRB_OFF_REV         15'h0006
`define SCRB_OFF_MAKER_HI    15'h000C
`define SCRB_OFF_MAKER_LO    15'h000D
`define SCRB_OFF_USER        15'h0010
`define SCRB_ADDR_TOP        15'h7FFF

`define SCRB_BIT_SOFT_RESET  7
`define SCRB_BIT_DIRECTION   5
`define SCRB_BIT_ONE         4
`define SCRB_BIT_HOLD        0

`define SCRB_RST_DIRECTION   1'h1
`define SCRB_RST_POWER       2'h0
`define SCRB_RST_HOLD        1'h0
`define SCRB_RST_CONFIG_B_RESERVED        8'h00
`define SCRB_PWR_DOWN_BIT    1

`endif

//--- hw/scrb_serial_config_register_bank.v
// serial configuration register bank: 3-wire byte port, streaming address, identity registers
`timescale 1ns/1ps
`include "scrb_map.vh"

module scrb_serial_config_register_bank #(
    parameter [3:0]  PART_CLASS = 4'h9,     // arbitrary value
    parameter [7:0]  PART_REV   = 8'h5A,    // arbitrary value
    parameter [15:0] MAKER_CODE = 16'hA5C3  // arbitrary value
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        nrst,
    // serial control port (3-wire, mode 0, first bit is read flag)
    input  wire        spi_cs_n,
    input  wire        spi_sclk,
    input  wire        spi_sdi,
    output reg         spi_sdo,
    output reg         spi_sdo_oe,
    // state toward the converter
    output reg         power_down,
    output reg         address_direction,
    output reg         address_hold,
    output reg  [1:0]  power_mode
);

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    reg [2:0] cs_meta;
    reg [2:0] cs_sync;
    reg       sclk_meta;
    reg       sclk_sync;
    reg       sclk_last;
    reg       sdi_meta;
    reg       sdi_sync;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cs_meta   <= 3'h7;
            cs_sync   <= 3'h7;
            sclk_meta <= 1'h0;
            sclk_sync <= 1'h0;
            sclk_last <= 1'h0;
            sdi_meta  <= 1'h0;
            sdi_sync  <= 1'h0;
        end else begin
            cs_meta   <= {cs_meta[2:1], spi_cs_n};
            cs_sync   <= {cs_sync[1:0], cs_meta[0]};
            sclk_meta <= spi_sclk;
            sclk_sync <= sclk_meta;
            sclk_last <= sclk_sync;
            sdi_meta  <= spi_sdi;
            sdi_sync  <= sdi_meta;
        end
    end

    wire cs_active = ~cs_sync[0];
    wire cs_start  = cs_sync[1] & ~cs_sync[0];
    wire sclk_rise = sclk_sync & ~sclk_last;
    wire sclk_fall = ~sclk_sync & sclk_last;

    //////////////////////////////////////////////////////////////////////////
    // helpers

    // mirror check: bit i must equal bit 7-i
    function mirror_ok;
        input [7:0] d;
        begin
            mirror_ok = (d[3] == d[4]) && (d[2] == d[5]) && (d[1] == d[6]) && (d[0] == d[7]);
        end
    endfunction

    function [14:0] step_addr;
        input [14:0] a;
        input        up;
        input        hold;
        begin
            if (hold)
                step_addr = a;
            else if (up)
                step_addr = (a == `SCRB_ADDR_TOP) ? 15'h0000 : a + 15'h0001;
            else
                step_addr = (a == 15'h0000) ? `SCRB_ADDR_TOP : a - 15'h0001;
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // register state

    reg        soft_reset_bit;
    reg [14:0] cur_addr;
    reg        rd_flag;
    reg [4:0]  bit_cnt;
    reg [7:0]  shift_in;
    reg [7:0]  shift_out;
    reg        in_data;

    reg [7:0]  read_byte;

    always @* begin
        case (cur_addr)
            `SCRB_OFF_CONFIG_A_RESET_AND_DIRECTION:
                read_byte = {soft_reset_bit, 1'h0, address_direction, 1'h1,
                             1'h1, address_direction, 1'h0, soft_reset_bit};
            `SCRB_OFF_CONFIG_B_RESERVED:     read_byte = `SCRB_RST_CONFIG_B_RESERVED;
            `SCRB_OFF_POWER:    read_byte = {6'h00, power_mode};
            `SCRB_OFF_CLASS:    read_byte = {4'h0, PART_CLASS};
            `SCRB_OFF_REV:      read_byte = PART_REV;
            `SCRB_OFF_MAKER_HI: read_byte = MAKER_CODE[15:8];
            `SCRB_OFF_MAKER_LO: read_byte = MAKER_CODE[7:0];
            `SCRB_OFF_USER:     read_byte = {7'h00, address_hold};
            default:            read_byte = 8'h00;
        endcase
    end

    wire [7:0] next_shift_in = {shift_in[6:0], sdi_sync};
    wire       byte_done     = sclk_rise && in_data && (bit_cnt[2:0] == 3'h7);

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            soft_reset_bit    <= 1'h0;
            address_direction <= `SCRB_RST_DIRECTION;
            address_hold      <= `SCRB_RST_HOLD;
            power_mode        <= `SCRB_RST_POWER;
            power_down        <= 1'h0;
            cur_addr          <= 15'h0000;
            rd_flag           <= 1'h0;
            bit_cnt           <= 5'h00;
            shift_in          <= 8'h00;
            shift_out         <= 8'h00;
            in_data           <= 1'h0;
            spi_sdo           <= 1'h0;
            spi_sdo_oe        <= 1'h0;
        end else begin
            // codes 2 and 3 both power down; no partial modes exist
            power_down <= power_mode[`SCRB_PWR_DOWN_BIT];
            if (soft_reset_bit) begin
                // one cycle pulse; direction deliberately untouched
                soft_reset_bit <= 1'h0;
                address_hold   <= `SCRB_RST_HOLD;
                power_mode     <= `SCRB_RST_POWER;
            end
            if (!cs_active || cs_start) begin
                bit_cnt    <= 5'h00;
                in_data    <= 1'h0;
                spi_sdo_oe <= 1'h0;
                spi_sdo    <= 1'h0;
            end else begin
                if (sclk_rise) begin
                    shift_in <= next_shift_in;
                    if (!in_data) begin
                        if (bit_cnt == 5'h00)
                            rd_flag <= sdi_sync;
                        else
                            cur_addr <= {cur_addr[13:0], sdi_sync};
                        if (bit_cnt == 5'h0F) begin
                            in_data   <= 1'h1;
                            bit_cnt   <= 5'h00;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end else begin
                        bit_cnt <= {2'h0, bit_cnt[2:0] + 3'h1};
                    end
                end
                if (byte_done) begin
                    if (!rd_flag) begin
                        case (cur_addr)
                            `SCRB_OFF_CONFIG_A_RESET_AND_DIRECTION:
                                if (mirror_ok(next_shift_in)) begin
                                    address_direction <=
                                        next_shift_in[`SCRB_BIT_DIRECTION];
                                    soft_reset_bit <=
                                        next_shift_in[`SCRB_BIT_SOFT_RESET];
                                end
                            `SCRB_OFF_POWER: power_mode <= next_shift_in[1:0];
                            `SCRB_OFF_USER:
                                address_hold <= next_shift_in[`SCRB_BIT_HOLD];
                            default: ;
                        endcase
                    end
                    cur_addr <= step_addr(cur_addr, address_direction, address_hold);
                end
                // read data: load at the start of each byte, shift otherwise; both on falling edge
                if (sclk_fall && in_data && rd_flag) begin
                    spi_sdo_oe <= 1'h1;
                    if (bit_cnt[2:0] == 3'h0) begin
                        spi_sdo   <= read_byte[7];
                        shift_out <= {read_byte[6:0], 1'h0};
                    end else begin
                        spi_sdo   <= shift_out[7];
                        shift_out <= {shift_out[6:0], 1'h0};
                    end
                end
            end
        end
    end

endmodule // scrb_serial_config_register_bank

//--- tb/scrb_asserts.sv
// port checker for the serial configuration register bank
`timescale 1ns/1ps
module scrb_asserts (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       nrst,
    // serial pins
    input wire logic       spi_cs_n,
    input wire logic       spi_sclk,
    input wire logic       spi_sdo,
    input wire logic       spi_sdo_oe,
    // converter state
    input wire logic       power_down,
    input wire logic       address_direction,
    input wire logic       address_hold,
    input wire logic [1:0] power_mode
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_rst_val; $rose(nrst) |-> address_direction && !address_hold && !power_mode; endproperty
    a_rst_val: assert property (p_rst_val) else $error("bad reset value");
    property p_pd_map; 1'b1 |-> power_down == $past(power_mode[1]); endproperty
    a_pd_map: assert property (p_pd_map) else $error("power down wrong");
    property p_pd_follow; $changed(power_mode) |-> ##[1:3] power_down == power_mode[1]; endproperty
    a_pd_follow: assert property (p_pd_follow) else $error("power down late");
    property p_oe_idle; spi_cs_n [*5] |-> !spi_sdo_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("sdo driven idle");
    property p_oe_start; $rose(spi_sdo_oe) |-> !spi_cs_n && !spi_sclk; endproperty
    a_oe_start: assert property (p_oe_start) else $error("sdo enable early");
    property p_sdo_hold; spi_sdo_oe && spi_sclk && $past(spi_sclk, 4) |-> $stable(spi_sdo); endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved");
    property p_dir_idle; spi_cs_n [*8] |-> $stable(address_direction); endproperty
    a_dir_idle: assert property (p_dir_idle) else $error("direction moved");
    property p_hold_idle; spi_cs_n [*8] |-> $stable(address_hold); endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("hold moved");
endmodule // scrb_asserts

bind scrb_serial_config_register_bank scrb_asserts scrb_asserts_i (.clk_sys, .nrst,
    .spi_cs_n, .spi_sclk, .spi_sdo, .spi_sdo_oe, .power_down, .address_direction,
    .address_hold, .power_mode);

//--- tb/scrb_host.sv
// serial host model for the three-wire control port
`timescale 1ns/1ps
module scrb_host (
    // clock
    input  wire logic clk_sys,
    // serial pins
    output logic      spi_cs_n,
    output logic      spi_sclk,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi  = 1'b0;
    end
    // five clocks a phase keeps sclk below clk_sys/8
    task automatic half;
        repeat (5) @(posedge clk_sys);
    endtask
    // read flag, address, then n bytes from the top of wd
    task automatic xfer(input logic r, input logic [14:0] a, input int n,
                        input logic [31:0] wd, output logic [31:0] rd);
        logic [47:0] sh;
        sh = {r, a, wd};
        rd = 32'h00000000;
        spi_cs_n <= 1'b0;
        for (int i = 0; i < 16 + 8 * n; i++) begin
            spi_sdi <= sh[47 - i];
            half;
            spi_sclk <= 1'b1;
            rd = (i < 16) ? 32'h00000000 : {rd[30:0], spi_sdo};
            half;
            spi_sclk <= 1'b0;
        end
        half;
        spi_cs_n <= 1'b1;
        // released line must not keep its last level
        spi_sdi  <= ~spi_sdi;
        half;
    endtask
endmodule // scrb_host

//--- tb/scrb_serial_config_register_bank_test.sv
// self-checking bench for the serial configuration register bank
`timescale 1ns/1ps
module scrb_serial_config_register_bank_test;
    localparam logic [3:0]  CLS = 4'h6;     // arbitrary value
    localparam logic [7:0]  REV = 8'h2E;    // arbitrary value
    localparam logic [15:0] MKR = 16'h7B1D; // arbitrary value
    logic        clk_sys = 1'b0;
    logic        nrst    = 1'b0;
    logic [31:0] got;
    int          fail_count  = 0;
    int          check_count = 0;
    wire logic   spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, power_down;
    wire logic   address_direction, address_hold;
    wire logic [1:0] power_mode;
    always #50 clk_sys = ~clk_sys;
    scrb_serial_config_register_bank #(.PART_CLASS(CLS), .PART_REV(REV), .MAKER_CODE(MKR))
        scrb_serial_config_register_bank_i (.clk_sys, .nrst, .spi_cs_n, .spi_sclk, .spi_sdi,
        .spi_sdo, .spi_sdo_oe, .power_down, .address_direction, .address_hold, .power_mode);
    scrb_host scrb_host_i (.clk_sys, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        scrb_host_i.xfer(1'b0, a, 1, {d, 24'h000000}, got);
    endtask
    task automatic rd(input string nm, input logic [14:0] a, input int n, input logic [31:0] e);
        scrb_host_i.xfer(1'b1, a, n, 32'h00000000, got);
        chk(nm, e, got);
        chk("sdo_oe_idle", 32'h0, {31'h0, spi_sdo_oe});
    endtask
    task automatic pins(input logic [3:0] e);
        chk("pins", {28'h0, e}, {28'h0, address_direction, address_hold, power_mode});
    endtask
    task automatic final_report;
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // 31 transfers of at most 500 clocks each
    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        final_report;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        pins(4'h8);
        rd("config_a_reset_and_direction", 15'h0000, 1, 32'h3C);
        rd("config_b_reserved", 15'h0001, 1, 32'h00);
        rd("class", 15'h0003, 1, {28'h0, CLS});
        wr(15'h0006, ~REV);
        wr(15'h0001, 8'hFF);
        rd("rev", 15'h0006, 1, {24'h0, REV});
        rd("config_b_reserved_wr", 15'h0001, 1, 32'h00);
        rd("maker", 15'h000C, 2, {16'h0, MKR});
        rd("wrap_up", 15'h7FFF, 2, 32'h003C);
        rd("unmapped", 15'h000E, 1, 32'h00);
        for (int m = 0; m < 4; m++) begin
            wr(15'h0002, 8'(m));
            rd("mode", 15'h0002, 1, m);
            chk("power_down", m / 2, {31'h0, power_down});
        end
        wr(15'h0000, 8'h12);
        rd("bad_config_a_reset_and_direction", 15'h0000, 1, 32'h3C);
        wr(15'h0010, 8'h01);
        pins(4'hF);
        rd("hold", 15'h000C, 2, {16'h0, MKR[15:8], MKR[15:8]});
        wr(15'h0010, 8'h00);
        wr(15'h0000, 8'h18);
        pins(4'h3);
        rd("down", 15'h000D, 3, {8'h0, MKR[7:0], MKR[15:8], 8'h00});
        rd("wrap_down", 15'h0000, 2, 32'h1800);
        wr(15'h0010, 8'h01);
        wr(15'h0000, 8'h81);
        pins(4'h0);
        rd("self_clear", 15'h0000, 1, 32'h18);
        rd("user", 15'h0010, 1, 32'h00);
        wr(15'h0000, 8'hA5);
        pins(4'h8);
        final_report;
    end
endmodule // scrb_serial_config_register_bank_test
